// file: design/serdes_tx_consts.vh
// Constants shared by the transmit serializer path
`ifndef SERDES_TX_CONSTS_VH
`define SERDES_TX_CONSTS_VH

// ****************************************
// Word and line geometry
// ****************************************
`define TXS_WORD_W           16
`define TXS_BYTE_W           8
`define TXS_CHAR_W           10
`define TXS_LINE_W           20
`define TXS_LO_BYTE_LSB      0
`define TXS_HI_BYTE_LSB      8
`define TXS_LO_CHAR_LSB      0
`define TXS_HI_CHAR_LSB      10

// ****************************************
// Bit clock and latency
// ****************************************
`define TXS_BIT_CLK_MULT     10
`define TXS_EDGES_PER_BIT    2
`define TXS_BITS_PER_WORD    (`TXS_BIT_CLK_MULT * `TXS_EDGES_PER_BIT)
`define TXS_REF_CLK_MIN_MHZ  80
`define TXS_REF_CLK_MAX_MHZ  135
`define TXS_LAT_MIN_BITS     34
`define TXS_LAT_MAX_BITS     38
`define TXS_PIPE_WORDS       1
`define TXS_SHIFT_OFS_BITS   16
`define TXS_LAT_BITS         (`TXS_PIPE_WORDS * `TXS_BITS_PER_WORD + `TXS_SHIFT_OFS_BITS)
`define TXS_FILL_CYCLES      2'h2

// ****************************************
// Code points and reset values
// ****************************************
`define TXS_K28_LOW5         5'h1C
`define TXS_K28_ABCDEI       6'h0F
`define TXS_ALT7_FGHJ        4'h7
`define TXS_RD_RESET         1'h0
`define TXS_PRBS_W           7
`define TXS_PRBS_SEED        7'h7F
`define TXS_PRBS_TAP_A       6
`define TXS_PRBS_TAP_B       5

`endif

// file: design/prbs7_word_gen.v
// Pattern generator: 2^7-1 sequence delivered a whole line word per clock
`timescale 1ns/1ps
`include "serdes_tx_consts.vh"

module prbs7_word_gen #(
	parameter W = `TXS_LINE_W
) (
	input  wire         i_ref_clk,
	input  wire         i_sys_rst,
	input  wire         i_en,
	output reg  [W-1:0] o_bits
);

	reg [`TXS_PRBS_W-1:0] lfsr_ff;
	reg [`TXS_PRBS_W-1:0] nxt_lfsr;
	reg [W-1:0]           nxt_bits;
	reg                   fb;
	integer               i;

	// ****************************************
	// Advance W steps; first generated bit lands in bit 0
	// ****************************************
	always @* begin
		nxt_lfsr = lfsr_ff;
		nxt_bits = {W{1'b0}};
		fb       = 1'b0;
		for (i = 0; i < W; i = i + 1) begin
			fb       = nxt_lfsr[`TXS_PRBS_TAP_A] ^ nxt_lfsr[`TXS_PRBS_TAP_B];
			nxt_lfsr = {nxt_lfsr[`TXS_PRBS_W-2:0], fb};
			nxt_bits[i] = fb;
		end
	end

	// Sequence is held while disabled so it restarts where it stopped
	always @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			lfsr_ff <= `TXS_PRBS_SEED;
			o_bits  <= {W{1'b0}};
		end else if (i_en) begin
			lfsr_ff <= nxt_lfsr;
			o_bits  <= nxt_bits;
		end
	end

endmodule

// file: design/serdes_tx_path.v
// Transmit path: word capture, dual 8b/10b encode, line word for the bit-rate shifter
`timescale 1ns/1ps
`include "serdes_tx_consts.vh"

// Functional notes
// (R1) A high low-byte control flag makes the low byte a K character, otherwise a D character.
// (R2) A high high-byte control flag makes the high byte a K character, otherwise a D character.
// (R3) The upstream side supplies a continuous word clock between 80 and 135 MHz.
// (R4) The full 16-bit word and both control flags are registered on every rising word clock edge.
// (R5) The upstream side holds word and flags stable around each rising edge, one word per edge.
// (R6) A bit clock at ten times the word clock feeds the parallel-to-serial shifter.
// (R7) One bit leaves on each bit clock edge, rise and fall, giving twenty bits per word period.
// (R8) The line word is ordered least significant bit first, bit zero leading on the line.
// (R9) Load-to-bit-zero delay lies between 34 and 38 bit times.
// (R10) Transmit latency is fixed from word to word once running.
// (R11) Each 16-bit word splits into two bytes, each encoded on its own under its own flag.
// (R12) Each byte maps to a ten-bit character of the standard 8b/10b code.
// (R13) Running disparity is tracked and the matching character form chosen to keep DC balance.
// (R14) The factory test enable input is left unconnected or held low in normal use.
// (R15) In pattern test mode the parallel input is ignored and a pseudo-random sequence is sent.
// (R16) The shifter takes the 20-bit word built from both encoder outputs as one stream.
// (R17) Low byte ending disparity seeds the high byte, whose ending disparity seeds the next word.

module serdes_tx_path #(
	parameter WORD_W   = `TXS_WORD_W,
	parameter LINE_W   = `TXS_LINE_W,
	parameter BIT_MULT = `TXS_BIT_CLK_MULT
) (
	input  wire              i_ref_clk,
	input  wire              i_sys_rst,
	input  wire [WORD_W-1:0] i_transmit_parallel_word,
	input  wire              i_low_byte_control_char_flag,
	input  wire              i_high_byte_control_char_flag,
	input  wire              i_pattern_test_enable,
	input  wire              i_factory_test_enable,
	output reg  [LINE_W-1:0] o_line_word,
	output reg  [3:0]        o_bit_clk_mult,
	output reg               o_running_disparity,
	output reg               o_pattern_active,
	output reg               o_link_ready
);

	// ****************************************
	// 5b/6b table, negative disparity form, written abcdei
	// ****************************************
	function [5:0] tab6;
		input [4:0] x;
		begin
			case (x)
				5'h00:   tab6 = 6'h27;
				5'h01:   tab6 = 6'h1D;
				5'h02:   tab6 = 6'h2D;
				5'h03:   tab6 = 6'h31;
				5'h04:   tab6 = 6'h35;
				5'h05:   tab6 = 6'h29;
				5'h06:   tab6 = 6'h19;
				5'h07:   tab6 = 6'h38;
				5'h08:   tab6 = 6'h39;
				5'h09:   tab6 = 6'h25;
				5'h0A:   tab6 = 6'h15;
				5'h0B:   tab6 = 6'h34;
				5'h0C:   tab6 = 6'h0D;
				5'h0D:   tab6 = 6'h2C;
				5'h0E:   tab6 = 6'h1C;
				5'h0F:   tab6 = 6'h17;
				5'h10:   tab6 = 6'h1B;
				5'h11:   tab6 = 6'h23;
				5'h12:   tab6 = 6'h13;
				5'h13:   tab6 = 6'h32;
				5'h14:   tab6 = 6'h0B;
				5'h15:   tab6 = 6'h2A;
				5'h16:   tab6 = 6'h1A;
				5'h17:   tab6 = 6'h3A;
				5'h18:   tab6 = 6'h33;
				5'h19:   tab6 = 6'h26;
				5'h1A:   tab6 = 6'h16;
				5'h1B:   tab6 = 6'h36;
				5'h1C:   tab6 = 6'h0E;
				5'h1D:   tab6 = 6'h2E;
				5'h1E:   tab6 = 6'h1E;
				5'h1F:   tab6 = 6'h2B;
				default: tab6 = 6'h27;
			endcase
		end
	endfunction

	// ****************************************
	// 3b/4b table, negative disparity form, written fghj
	// ****************************************
	function [3:0] tab4;
		input [2:0] y;
		begin
			case (y)
				3'h0:    tab4 = 4'hB;
				3'h1:    tab4 = 4'h9;
				3'h2:    tab4 = 4'h5;
				3'h3:    tab4 = 4'hC;
				3'h4:    tab4 = 4'hD;
				3'h5:    tab4 = 4'hA;
				3'h6:    tab4 = 4'h6;
				3'h7:    tab4 = 4'hE;
				default: tab4 = 4'hB;
			endcase
		end
	endfunction

	// ****************************************
	// One byte encoder: returns {ending disparity, character}
	// Disparity 1 means positive; character bit 0 is bit a, first on the line
	// ****************************************
	function [10:0] enc_byte;
		input [7:0] d;
		input       k;
		input       rd;
		reg   [5:0] s6;
		reg   [5:0] c6;
		reg   [3:0] s4;
		reg   [3:0] c4;
		reg   [2:0] ones;
		reg         unbal6;
		reg         r6;
		reg         alt;
		reg         inv4;
		reg         bal4;
		reg   [9:0] m;
		reg   [9:0] c;
		integer     i;
		begin
			s6     = (k && d[4:0] == `TXS_K28_LOW5) ? `TXS_K28_ABCDEI : tab6(d[4:0]);
			ones   = {2'h0, s6[0]} + {2'h0, s6[1]} + {2'h0, s6[2]} + {2'h0, s6[3]} +
			         {2'h0, s6[4]} + {2'h0, s6[5]};
			unbal6 = (ones != 3'h3);
			// D.7 is balanced but still has two forms
			c6     = (rd && (unbal6 || (!k && d[4:0] == 5'h07))) ? ~s6 : s6; // [R13]
			r6     = unbal6 ? ~rd : rd;
			// Alternate x.7 avoids a run of five equal bits across the boundary
			alt    = (d[7:5] == 3'h7) && (k ||
			         (!r6 && (d[4:0] == 5'h11 || d[4:0] == 5'h12 || d[4:0] == 5'h14)) ||
			         (r6 && (d[4:0] == 5'h0B || d[4:0] == 5'h0D || d[4:0] == 5'h0E)));
			s4     = alt ? `TXS_ALT7_FGHJ : tab4(d[7:5]);
			bal4   = !(d[7:5] == 3'h0 || d[7:5] == 3'h4 || d[7:5] == 3'h7);
			inv4   = (r6 && (d[7:5] == 3'h0 || d[7:5] == 3'h3 || d[7:5] == 3'h4 || d[7:5] == 3'h7)) ||
			         (k && !r6 && (d[7:5] == 3'h1 || d[7:5] == 3'h2 ||
			                       d[7:5] == 3'h5 || d[7:5] == 3'h6)); // [R1] [R2]
			c4     = inv4 ? ~s4 : s4; // [R13]
			m      = {c6, c4};
			c      = 10'h000;
			for (i = 0; i < 10; i = i + 1) begin
				c[i] = m[9-i]; // [R8]
			end
			enc_byte = {(bal4 ? r6 : ~r6), c}; // [R12]
		end
	endfunction

	// ****************************************
	// Input capture
	// ****************************************
	reg  [WORD_W-1:0] word_ff;
	reg               lo_k_ff;
	reg               hi_k_ff;
	reg               pat_ff;
	reg               rd_ff;
	reg  [1:0]        fill_ff;
	reg  [1:0]        nxt_fill;
	reg  [10:0]       lo_enc;
	reg  [10:0]       hi_enc;
	reg  [LINE_W-1:0] nxt_line;
	reg               nxt_rd;
	wire [LINE_W-1:0] prbs_bits;

	// Every edge loads a word; there is no valid strobe on this interface
	always @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			word_ff <= {WORD_W{1'b0}};
			lo_k_ff <= 1'b0;
			hi_k_ff <= 1'b0;
			pat_ff  <= 1'b0;
		end else begin
			word_ff <= i_transmit_parallel_word; // [R4]
			lo_k_ff <= i_low_byte_control_char_flag; // [R4]
			hi_k_ff <= i_high_byte_control_char_flag; // [R4]
			pat_ff  <= i_pattern_test_enable;
		end
	end

	// ****************************************
	// Pattern source
	// ****************************************
	// Generator runs a stage early so its word lines up with the captured enable
	prbs7_word_gen #(
		.W (LINE_W)
	) u_prbs (
		.i_ref_clk (i_ref_clk),
		.i_sys_rst (i_sys_rst),
		.i_en      (i_pattern_test_enable),
		.o_bits    (prbs_bits)
	);

	// ****************************************
	// Encode and assemble the line word
	// ****************************************
	always @* begin
		lo_enc = enc_byte(word_ff[`TXS_LO_BYTE_LSB +: `TXS_BYTE_W], lo_k_ff, rd_ff); // [R11] [R1] [R17]
		hi_enc = enc_byte(word_ff[`TXS_HI_BYTE_LSB +: `TXS_BYTE_W], hi_k_ff, lo_enc[10]); // [R11] [R2] [R17]
		if (pat_ff) begin
			// Input word is dropped; disparity is held across the pattern burst
			nxt_line = prbs_bits; // [R15]
			nxt_rd   = rd_ff;
		end else begin
			nxt_line = {hi_enc[9:0], lo_enc[9:0]}; // [R16] [R8]
			nxt_rd   = hi_enc[10]; // [R17] [R13]
		end
		nxt_fill = (fill_ff == `TXS_FILL_CYCLES) ? fill_ff : fill_ff + 2'h1;
	end

	// ****************************************
	// Line word register
	// ****************************************
	// One fixed register stage between capture and shifter keeps latency constant.
	// The analog multiplier and double-edge shifter take o_line_word from here and
	// add a fixed offset, so load to bit zero is one word plus that offset.
	always @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			o_line_word         <= {LINE_W{1'b0}};
			rd_ff               <= `TXS_RD_RESET;
			o_running_disparity <= `TXS_RD_RESET;
			o_pattern_active    <= 1'b0;
			fill_ff             <= 2'h0;
			o_link_ready        <= 1'b0;
			o_bit_clk_mult      <= 4'h0;
		end else begin
			o_line_word         <= nxt_line; // [R9] [R10] [R7]
			rd_ff               <= nxt_rd; // [R13]
			o_running_disparity <= nxt_rd;
			o_pattern_active    <= pat_ff;
			fill_ff             <= nxt_fill;
			o_link_ready        <= (nxt_fill == `TXS_FILL_CYCLES); // [R10]
			o_bit_clk_mult      <= BIT_MULT[3:0]; // [R6]
		end
	end

	// Factory test enable has no function in this path and is expected low.
	// Left unread on purpose rather than given an undocumented meaning.

endmodule

// file: tb/proto_word_src.sv
// Protocol-side source of parallel words and control flags
`timescale 1ns/1ps

module proto_word_src (
	input  wire        i_ref_clk,
	input  wire        i_force,
	input  wire [15:0] i_word,
	input  wire        i_klo,
	input  wire        i_khi,
	output wire [15:0] o_word,
	output wire        o_klo,
	output wire        o_khi
);
	integer    seed     = 37;
	reg [31:0] rnd_ff   = 32'h0000_0000;
	reg [31:0] kmask_ff = 32'h0000_0000;
	// New random word shortly after every rising edge, held to the next one
	always @(posedge i_ref_clk) begin
		#2;
		rnd_ff = $random(seed);
		kmask_ff = $random(seed) & $random(seed);
	end
	// Random K flags only ever go with a comma byte, so no invalid K code appears
	assign o_word = i_force ? i_word : {kmask_ff[1] ? 8'hBC : rnd_ff[15:8], kmask_ff[0] ? 8'hBC : rnd_ff[7:0]};
	assign o_klo  = i_force ? i_klo : kmask_ff[0];
	assign o_khi  = i_force ? i_khi : kmask_ff[1];
endmodule

// file: tb/serdes_tx_path_chk.sv
// Concurrent checks on the transmit path ports
`timescale 1ns/1ps

module serdes_tx_path_chk #(
	parameter WORD_W = 16,
	parameter LINE_W = 20
) (
	input wire              i_ref_clk,
	input wire              i_sys_rst,
	input wire [WORD_W-1:0] i_transmit_parallel_word,
	input wire              i_low_byte_control_char_flag,
	input wire              i_high_byte_control_char_flag,
	input wire              i_pattern_test_enable,
	input wire              i_factory_test_enable,
	input wire [LINE_W-1:0] o_line_word,
	input wire [3:0]        o_bit_clk_mult,
	input wire              o_running_disparity,
	input wire              o_pattern_active,
	input wire              o_link_ready
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);
	function automatic logic nrd(input logic rd, input logic [9:0] ch);
		nrd = ($countones(ch) == 5) ? rd : ~rd;
	endfunction
	function automatic logic fair(input logic rd, input logic [9:0] ch);
		fair = rd ? ($countones(ch) <= 5) : ($countones(ch) >= 5);
	endfunction
	function automatic logic comma(input logic [9:0] ch);
		comma = (ch[6:0] == 7'h7C) || (ch[6:0] == 7'h03);
	endfunction
	// ****************************************
	// Encoded word two edges after capture
	// ****************************************
	sequence s_taken;
		!i_sys_rst ##1 !i_sys_rst ##1 !o_pattern_active;
	endsequence
	a_char_weight: assert property (s_taken |-> $countones(o_line_word[9:0]) inside {[4:6]} &&
		$countones(o_line_word[19:10]) inside {[4:6]}) else $error("character weight out of range");
	a_rd_choice: assert property (s_taken |-> fair($past(o_running_disparity), o_line_word[9:0]) &&
		fair(nrd($past(o_running_disparity), o_line_word[9:0]), o_line_word[19:10])) else $error("wrong character form");
	a_rd_chain: assert property (s_taken |-> o_running_disparity ==
		nrd(nrd($past(o_running_disparity), o_line_word[9:0]), o_line_word[19:10])) else $error("disparity chain broken");
	a_k_low: assert property (s_taken ##0 ($past(i_transmit_parallel_word[7:0], 2) == 8'hBC) |->
		comma(o_line_word[9:0]) == $past(i_low_byte_control_char_flag, 2)) else $error("low byte K or D wrong");
	a_k_high: assert property (s_taken ##0 ($past(i_transmit_parallel_word[15:8], 2) == 8'hBC) |->
		comma(o_line_word[19:10]) == $past(i_high_byte_control_char_flag, 2)) else $error("high byte K or D wrong");
	a_pat_follow: assert property (!i_sys_rst ##1 !i_sys_rst |=>
		o_pattern_active == $past(i_pattern_test_enable, 2)) else $error("pattern flag late or wrong");
	a_rd_hold: assert property (!i_sys_rst ##1 o_pattern_active |->
		$stable(o_running_disparity)) else $error("disparity moved in pattern mode");
	a_mult_ten: assert property (!$past(i_sys_rst) |-> o_bit_clk_mult == 4'hA) else $error("bit clock multiplier wrong");
	a_ready_fill: assert property ($past(i_sys_rst, 2) && !$past(i_sys_rst) |->
		##[0:1] o_link_ready) else $error("link not ready after fill");
	a_ready_stays: assert property (o_link_ready |=> o_link_ready) else $error("link ready dropped");
endmodule

bind serdes_tx_path serdes_tx_path_chk #(.WORD_W(WORD_W), .LINE_W(LINE_W)) chk (.i_ref_clk, .i_sys_rst,
	.i_transmit_parallel_word, .i_low_byte_control_char_flag, .i_high_byte_control_char_flag,
	.i_pattern_test_enable, .i_factory_test_enable, .o_line_word, .o_bit_clk_mult,
	.o_running_disparity, .o_pattern_active, .o_link_ready);

// file: tb/tb_top.sv
// Self-checking bench for the transmit path
`timescale 1ns/1ps
`include "serdes_tx_consts.vh"

module tb_top;
	reg                    clk      = 1'b0;
	reg                    rst      = 1'b1;
	reg                    pat_en   = 1'b0;
	reg                    force_on = 1'b1;
	reg  [`TXS_WORD_W-1:0] f_word   = 16'hBCBC;
	reg  [1:0]             f_k      = 2'h0;
	wire [`TXS_WORD_W-1:0] word;
	wire                   klo;
	wire                   khi;
	wire [`TXS_LINE_W-1:0] line;
	wire [3:0]             mult;
	wire                   rd;
	wire                   pact;
	wire                   ready;
	integer                bad_count   = 0;
	integer                comparisons = 0;
	integer                i;
	integer                j;
	integer                cum;
	reg  [6:0]             ph;
	reg  [`TXS_LINE_W-1:0] exp_w;

	always #10 clk = ~clk; // Continuous word clock, slowed for simulation

	proto_word_src src (.i_ref_clk(clk), .i_force(force_on), .i_word(f_word), .i_klo(f_k[0]), .i_khi(f_k[1]),
		.o_word(word), .o_klo(klo), .o_khi(khi));
	// Factory test input held low as normal use demands
	serdes_tx_path dut (.i_ref_clk(clk), .i_sys_rst(rst), .i_transmit_parallel_word(word),
		.i_low_byte_control_char_flag(klo), .i_high_byte_control_char_flag(khi),
		.i_pattern_test_enable(pat_en), .i_factory_test_enable(1'b0), .o_line_word(line),
		.o_bit_clk_mult(mult), .o_running_disparity(rd), .o_pattern_active(pact), .o_link_ready(ready));

	function automatic logic has_comma(input logic [9:0] ch);
		has_comma = (ch[6:0] == 7'h7C) || (ch[6:0] == 7'h03);
	endfunction

	// Next pattern word from x^7+x^6+1; earliest generated bit lands in bit 0
	function automatic [`TXS_LINE_W+6:0] prbs_step(input [6:0] h);
		reg [6:0]             s;
		reg [`TXS_LINE_W-1:0] w;
		integer               n;
		begin
			s = h;
			w = {`TXS_LINE_W{1'b0}};
			for (n = 0; n < `TXS_LINE_W; n = n + 1) begin
				w[n] = s[6] ^ s[5];
				s = {s[5:0], w[n]};
			end
			prbs_step = {s, w};
		end
	endfunction

	task check(input [31:0] seen, input [31:0] exp, input [8*10:1] what);
		comparisons = comparisons + 1;
		if (seen !== exp) begin
			bad_count = bad_count + 1;
			$display("unexpected %0s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task give_verdict;
		$display("comparisons %0d bad_count %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Inputs change 2 ns after a rising edge; pattern enable rises with the release
	task hold_reset(input logic pat);
		rst = 1'b1;
		repeat (6) @(posedge clk);
		#2;
		rst = 1'b0;
		pat_en = pat;
	endtask

	initial begin
		#(20 * 2000);
		bad_count = bad_count + 1;
		give_verdict;
	end

	initial begin
		hold_reset(1'b0);
		// ****************************************
		// Comma byte under every flag pair, exact two-edge pipeline
		// ****************************************
		for (i = 0; i < 7; i = i + 1) begin
			@(posedge clk);
			#2;
			j = i - 2;
			if (i > 1) begin
				check(has_comma(line[9:0]), j[0], "low char");
				check(has_comma(line[19:10]), j[1], "high char");
			end
			f_k = i[1:0];
		end
		check(mult, 4'hA, "multiplier");
		check(ready, 1'b1, "ready");
		$display("test flags done");
		// ****************************************
		// Random stream: running digital sum stays balanced
		// ****************************************
		force_on = 1'b0;
		cum = rd;
		for (i = 0; i < 400; i = i + 1) begin
			@(posedge clk);
			#2;
			cum = cum + $countones(line[9:0]) - 5;
			check(cum == 0 || cum == 1, 1, "low sum");
			cum = cum + $countones(line[19:10]) - 5;
			check(cum == 0 || cum == 1, 1, "high sum");
			check(rd, cum[0], "disparity");
		end
		$display("test stream done");
		// ****************************************
		// Pattern mode twice from reset, data different each time
		// ****************************************
		for (j = 0; j < 2; j = j + 1) begin
			force_on = (j == 0);
			f_word = 16'h0000;
			ph = `TXS_PRBS_SEED;
			hold_reset(1'b1);
			for (i = 0; i < 10; i = i + 1) begin
				@(posedge clk);
				#2;
				if (i > 0) begin
					{ph, exp_w} = prbs_step(ph);
					check(pact, 1'b1, "pattern");
					check(line, exp_w, "pat word");
				end
			end
			pat_en = 1'b0;
		end
		$display("test pattern done");
		give_verdict;
	end
endmodule
